// ### common/hbw_params.svh
// Constants of the host bus wait and interrupt port.
// Assumes one 250 MHz core clock; included by the package and the design.
`ifndef HBW_PARAMS_SVH
`define HBW_PARAMS_SVH

// ======================================================================
// Clock and timing
`define HBW_CLK_PS 4000
`define HBW_POLL_PS 250000
`define HBW_PULSE_PS 200000
`define HBW_HOLD_LIMIT_PS 100000
`define HBW_POLL_CYC (`HBW_POLL_PS / `HBW_CLK_PS)
`define HBW_PULSE_CYC (`HBW_PULSE_PS / `HBW_CLK_PS)

// ======================================================================
// Register offsets on the processor port
`define HBW_REG_CTRL 3'h0
`define HBW_REG_LATCH 3'h1
`define HBW_REG_ACCESS 3'h2
`define HBW_REG_EVENT 3'h3
`define HBW_REG_ISTAT 3'h4
`define HBW_REG_IMASK 3'h5

// ======================================================================
// Fields and reset values
`define HBW_CTRL_PERMIT 0
`define HBW_EV_IRQ 0
`define HBW_EV_XFER 1
`define HBW_IS_ACCESS 0
`define HBW_IS_XFER_TAKEN 1
`define HBW_CTRL_RST 8'h00
`define HBW_MASK_RST 8'h00
`define HBW_LATCH_RST 8'h00

// ======================================================================
// Host task-file addresses that clear requests
`define HBW_TF_DATA 3'h0
`define HBW_TF_SECNUM 3'h3
`define HBW_TF_CYLLO 3'h4
`define HBW_TF_STATCMD 3'h7

`endif

// ### common/hbw_pkg.sv
// Types of the host bus wait and interrupt port.
// Assumes the constants header sits beside it on the include path.
package hbw_pkg;
`include "hbw_params.svh"

   // ===================================================================
   // Hold sequencing per card-select access
   typedef enum logic [1:0] {
      HS_IDLE,
      HS_HOLD,
      HS_DONE
   } hbw_hold_type;

endpackage

// ### design/hbw_port.sv
// Host bus port: bus hold, bus gating, access detection, irq and request.
// Assumes asynchronous host pins and an internal processor on core_clk_i.
`timescale 1ns/1ps
`include "hbw_params.svh"

module hbw_port
   import hbw_pkg::*;
#(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 3
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // Host pins
   input wire logic cs_n_i,
   input wire logic rd_strobe_n_i,
   input wire logic wr_strobe_n_i,
   input wire logic [ADDR_W-1:0] reg_sel_lines_i,
   input wire logic [DATA_W-1:0] host_data_bus_i,
   output logic [DATA_W-1:0] host_data_bus_o,
   output logic host_data_bus_oe_o,
   output logic wait_n_o,
   output logic irq_out_o,
   output logic xfer_request_o,
   input wire logic master_clear_n_i,
   // Processor register port
   input wire logic [2:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic intr_o,
   output logic host_access_pulse_n_o
);

   localparam int SYNC_W = DATA_W + ADDR_W + 4;
   localparam int POLL_CYC = `HBW_POLL_CYC;
   localparam int PULSE_CYC = `HBW_PULSE_CYC;

   initial begin
      if (DATA_W != 8 || ADDR_W != 3) begin
         $error("hbw_port serves only an 8-bit bus with 3 address lines");
      end
   end

   // ===================================================================
   // Pin synchronisers
   logic [SYNC_W-1:0] pin_s1_q;
   logic [SYNC_W-1:0] pin_s2_q;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pin_s1_q <= {4'hF, {(SYNC_W-4){1'b0}}};
         pin_s2_q <= {4'hF, {(SYNC_W-4){1'b0}}};
      end else begin
         pin_s1_q <= {master_clear_n_i, cs_n_i, rd_strobe_n_i,
                      wr_strobe_n_i, reg_sel_lines_i, host_data_bus_i};
         pin_s2_q <= pin_s1_q;
      end
   end

   logic mclr;
   logic cs;
   logic rd;
   logic wr;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;
   logic cs_prev_q;
   logic cs_fall;

   assign mclr = !pin_s2_q[SYNC_W-1];
   assign cs = !pin_s2_q[SYNC_W-2];
   assign rd = !pin_s2_q[SYNC_W-3];
   assign wr = !pin_s2_q[SYNC_W-4];
   assign addr_s = pin_s2_q[DATA_W +: ADDR_W];
   assign data_s = pin_s2_q[DATA_W-1:0];
   assign cs_fall = cs && !cs_prev_q;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         cs_prev_q <= 1'b0;
      end else begin
         cs_prev_q <= cs;
      end
   end

   // ===================================================================
   // Processor register decode
   logic wr_ctrl;
   logic wr_latch;
   logic rd_latch;
   logic wr_event;
   logic wr_istat;
   logic wr_imask;
   logic latch_strobe;

   assign wr_ctrl = reg_wr_i && reg_addr_i == `HBW_REG_CTRL;
   assign wr_latch = reg_wr_i && reg_addr_i == `HBW_REG_LATCH;
   assign rd_latch = reg_rd_i && reg_addr_i == `HBW_REG_LATCH;
   assign wr_event = reg_wr_i && reg_addr_i == `HBW_REG_EVENT;
   assign wr_istat = reg_wr_i && reg_addr_i == `HBW_REG_ISTAT;
   assign wr_imask = reg_wr_i && reg_addr_i == `HBW_REG_IMASK;
   assign latch_strobe = wr_latch || rd_latch;

   logic [7:0] ctrl_q;
   logic hold_permit_n;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         ctrl_q <= `HBW_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= reg_wdata_i;
      end
   end

   assign hold_permit_n = !ctrl_q[`HBW_CTRL_PERMIT];

   // ===================================================================
   // Bus hold sequencing
   hbw_hold_type hold_q;
   logic hold_request_internal;

   // Permit sampled only at select edge, so a hold never starts mid access
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         hold_q <= HS_IDLE;
      end else begin
         case (hold_q)
            HS_IDLE: begin
               if (cs_fall) begin
                  hold_q <= hold_permit_n ? HS_DONE : HS_HOLD;
               end
            end
            HS_HOLD: begin
               if (latch_strobe) begin
                  hold_q <= HS_DONE;
               end else if (!cs) begin
                  hold_q <= HS_IDLE;
               end
            end
            HS_DONE: begin
               if (!cs) begin
                  hold_q <= HS_IDLE;
               end
            end
            default: begin
               hold_q <= HS_IDLE;
            end
         endcase
      end
   end

   assign hold_request_internal = hold_q == HS_HOLD;
   // Held through the strobe cycle, drops at its trailing edge
   assign wait_n_o = !hold_request_internal;

   // ===================================================================
   // Bus gating and communication latches
   logic bus_out_gate_n;
   logic bus_in_gate;
   logic [DATA_W-1:0] out_latch_q;
   logic [DATA_W-1:0] in_latch_q;

   assign bus_out_gate_n = !(cs && rd);
   assign bus_in_gate = cs && wr;
   assign host_data_bus_oe_o = !bus_out_gate_n;
   assign host_data_bus_o = out_latch_q;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         out_latch_q <= `HBW_LATCH_RST;
      end else if (wr_latch) begin
         out_latch_q <= reg_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         in_latch_q <= `HBW_LATCH_RST;
      end else if (bus_in_gate) begin
         in_latch_q <= data_s;
      end
   end

   // ===================================================================
   // Access detection and host access pulse
   logic access_seen_q;
   logic access_set;
   logic [ADDR_W-1:0] acc_addr_q;
   logic acc_wr_q;
   logic [5:0] pulse_cnt_q;

   assign access_set = hold_request_internal && (rd || wr) &&
                       !access_seen_q && !latch_strobe;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         access_seen_q <= 1'b0;
         acc_addr_q <= 3'h0;
         acc_wr_q <= 1'b0;
      end else if (access_set) begin
         access_seen_q <= 1'b1;
         acc_addr_q <= addr_s;
         acc_wr_q <= wr;
      end else if (latch_strobe) begin
         access_seen_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pulse_cnt_q <= 6'h00;
      end else if (access_set) begin
         pulse_cnt_q <= 6'(PULSE_CYC);
      end else if (pulse_cnt_q != 6'h00) begin
         pulse_cnt_q <= pulse_cnt_q - 6'h01;
      end
   end

   assign host_access_pulse_n_o = pulse_cnt_q == 6'h00;

   // Snapshot on a fixed tick; the processor reads the latest sample
   logic [5:0] poll_cnt_q;
   logic [7:0] poll_snap_q;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         poll_cnt_q <= 6'h00;
         poll_snap_q <= 8'h00;
      end else if (poll_cnt_q == 6'(POLL_CYC - 1)) begin
         poll_cnt_q <= 6'h00;
         poll_snap_q <= {3'h0, acc_wr_q, acc_addr_q, access_seen_q};
      end else begin
         poll_cnt_q <= poll_cnt_q + 6'h01;
      end
   end

   // ===================================================================
   // Interrupt request and transfer request
   logic irq_set;
   logic xfer_set;
   logic irq_clr;
   logic xfer_clr;

   assign irq_set = wr_event && reg_wdata_i[`HBW_EV_IRQ];
   assign xfer_set = wr_event && reg_wdata_i[`HBW_EV_XFER];
   assign irq_clr = access_set && (addr_s == `HBW_TF_STATCMD ||
                                   addr_s == `HBW_TF_SECNUM);
   assign xfer_clr = access_set && (addr_s == `HBW_TF_DATA ||
                                    addr_s == `HBW_TF_CYLLO);

   // Set beats clear so an operation end is never lost
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || mclr) begin
         irq_out_o <= 1'b1;
      end else if (irq_set) begin
         irq_out_o <= 1'b1;
      end else if (irq_clr) begin
         irq_out_o <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || mclr) begin
         xfer_request_o <= 1'b0;
      end else if (xfer_set) begin
         xfer_request_o <= 1'b1;
      end else if (xfer_clr) begin
         xfer_request_o <= 1'b0;
      end
   end

   // ===================================================================
   // Processor interrupt status and mask
   logic [7:0] istat_q;
   logic [7:0] imask_q;
   logic [7:0] ev_vec;

   assign ev_vec = {6'h00, xfer_clr && xfer_request_o, access_set};

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         istat_q <= 8'h00;
      end else if (wr_istat) begin
         istat_q <= (istat_q & ~reg_wdata_i) | ev_vec;
      end else begin
         istat_q <= istat_q | ev_vec;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         imask_q <= `HBW_MASK_RST;
      end else if (wr_imask) begin
         imask_q <= reg_wdata_i;
      end
   end

   assign intr_o = |(istat_q & imask_q);

   // ===================================================================
   // Register read port
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || !reg_rd_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         case (reg_addr_i)
            `HBW_REG_CTRL: reg_rdata_o <= ctrl_q;
            `HBW_REG_LATCH: reg_rdata_o <= in_latch_q;
            `HBW_REG_ACCESS: reg_rdata_o <= poll_snap_q;
            `HBW_REG_EVENT: begin
               reg_rdata_o <= {6'h00, xfer_request_o, irq_out_o};
            end
            `HBW_REG_ISTAT: reg_rdata_o <= istat_q;
            `HBW_REG_IMASK: reg_rdata_o <= imask_q;
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // ===================================================================
   // Checks
   property p_hold_capture;
      @(posedge core_clk_i) disable iff (!nrst_i)
      hold_q == HS_IDLE && cs_fall && !hold_permit_n |=> !wait_n_o;
   endproperty
   a_hold_capture: assert property (p_hold_capture)
      else $error("hold not raised after permitted select");

   property p_hold_span;
      @(posedge core_clk_i) disable iff (!nrst_i)
      !wait_n_o && cs && !latch_strobe |=> !wait_n_o;
   endproperty
   a_hold_span: assert property (p_hold_span)
      else $error("hold dropped during access");

   property p_hold_release;
      @(posedge core_clk_i) disable iff (!nrst_i)
      !wait_n_o && latch_strobe |-> !wait_n_o ##1 wait_n_o;
   endproperty
   a_hold_release: assert property (p_hold_release)
      else $error("hold not released at strobe end");

   property p_no_hold;
      @(posedge core_clk_i) disable iff (!nrst_i)
      hold_q == HS_IDLE && cs_fall && hold_permit_n |=> wait_n_o[*2];
   endproperty
   a_no_hold: assert property (p_no_hold)
      else $error("hold raised without permit");

   property p_out_gate;
      @(posedge core_clk_i) disable iff (!nrst_i)
      cs && rd |-> host_data_bus_oe_o && host_data_bus_o == out_latch_q;
   endproperty
   a_out_gate: assert property (p_out_gate)
      else $error("latch not driven during host read");

   property p_in_gate;
      @(posedge core_clk_i) disable iff (!nrst_i)
      cs && wr |=> in_latch_q == $past(data_s);
   endproperty
   a_in_gate: assert property (p_in_gate)
      else $error("host data not captured");

   property p_seen;
      @(posedge core_clk_i) disable iff (!nrst_i)
      hold_request_internal && (rd || wr) && !latch_strobe |=> access_seen_q;
   endproperty
   a_seen: assert property (p_seen)
      else $error("access not detected");

   property p_pulse;
      @(posedge core_clk_i) disable iff (!nrst_i)
      access_set |=> !host_access_pulse_n_o[*8];
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("host access pulse too short");

   property p_irq_clear;
      @(posedge core_clk_i) disable iff (!nrst_i)
      access_set && addr_s == `HBW_TF_STATCMD && !irq_set && !mclr
      |=> !irq_out_o;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("interrupt not cleared by status access");

   property p_xfer_set;
      @(posedge core_clk_i) disable iff (!nrst_i)
      xfer_set && !mclr |=> xfer_request_o;
   endproperty
   a_xfer_set: assert property (p_xfer_set)
      else $error("transfer request not raised");

   property p_reset;
      @(posedge core_clk_i)
      !nrst_i |=> irq_out_o && !xfer_request_o;
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset values of irq or request wrong");

endmodule

// ### verif/hbw_host_model.sv
// Host bus model: card select, strobes, address and data toward the port.
// Assumes the hold line is sampled on the rising core clock edge.
`timescale 1ns/1ps
module hbw_host_model (
   input wire logic clk_i,
   input wire logic wait_n_i,
   output logic cs_n_o,
   output logic rd_strobe_n_o,
   output logic wr_strobe_n_o,
   output logic [2:0] reg_sel_lines_o,
   output logic [7:0] host_data_bus_o
);
   initial begin
      cs_n_o = 1'b1;
      rd_strobe_n_o = 1'b1;
      wr_strobe_n_o = 1'b1;
      reg_sel_lines_o = 3'h0;
      host_data_bus_o = 8'h00;
   end

   // ==================================================================
   // Access start: select, strobe, address and data in one edge
   task automatic start(input logic wr, input logic [2:0] a,
         input logic [7:0] d);
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      rd_strobe_n_o <= wr;
      wr_strobe_n_o <= !wr;
      reg_sel_lines_o <= a;
      host_data_bus_o <= d;
   endtask

   // ==================================================================
   // Access end: slow hosts hold min_cyc first, then wait out the hold
   task automatic finish(input int min_cyc, output logic ok);
      int n;
      n = 0;
      repeat (min_cyc) @(posedge clk_i);
      while (wait_n_i !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      ok = (n < 400);
      cs_n_o <= 1'b1;
      rd_strobe_n_o <= 1'b1;
      wr_strobe_n_o <= 1'b1;
      // Released lines flip so a stale value is never mistaken for data
      reg_sel_lines_o <= ~reg_sel_lines_o;
      host_data_bus_o <= ~host_data_bus_o;
      // Idle gap longer than the synchroniser needs
      repeat (4) @(posedge clk_i);
   endtask
endmodule

// ### verif/tb_hbw_port.sv
// Self-checking bench of the host bus port, with a host bus model.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "hbw_params.svh"
module tb_hbw_port
   import hbw_pkg::*;
;
   localparam logic [7:0] PULSE_LEN = 8'(`HBW_PULSE_CYC);
   logic clk, nrst, cs_n, rd_n, wr_n, oe, wait_n, irq, xfer, mclr_n;
   logic r_wr, r_rd, intr, pulse_n, hold_seen, ok;
   logic [2:0] sel, r_addr;
   logic [7:0] hdi, hdo, r_wdata, r_rdata, v;
   logic [31:0] seed, r;
   logic [2:0] addrs [6];
   int err_total, n_checks, pl_cnt, pl_last;

   hbw_port hbw_port_i (.core_clk_i(clk), .nrst_i(nrst), .cs_n_i(cs_n),
      .rd_strobe_n_i(rd_n), .wr_strobe_n_i(wr_n), .reg_sel_lines_i(sel),
      .host_data_bus_i(hdi), .host_data_bus_o(hdo),
      .host_data_bus_oe_o(oe), .wait_n_o(wait_n), .irq_out_o(irq),
      .xfer_request_o(xfer), .master_clear_n_i(mclr_n),
      .reg_addr_i(r_addr), .reg_wdata_i(r_wdata), .reg_wr_i(r_wr),
      .reg_rd_i(r_rd), .reg_rdata_o(r_rdata), .intr_o(intr),
      .host_access_pulse_n_o(pulse_n));

   hbw_host_model hbw_host_model_i (.clk_i(clk), .wait_n_i(wait_n),
      .cs_n_o(cs_n), .rd_strobe_n_o(rd_n), .wr_strobe_n_o(wr_n),
      .reg_sel_lines_o(sel), .host_data_bus_o(hdi));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Pulse length and hold watchers
   always @(posedge clk) begin
      if (pulse_n === 1'b0) begin
         pl_cnt <= pl_cnt + 1;
      end else begin
         if (pl_cnt != 0) pl_last <= pl_cnt;
         pl_cnt <= 0;
      end
      if (wait_n === 1'b0) hold_seen <= 1'b1;
   end

   // ==================================================================
   // Helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [7:0] exp_req(input logic [2:0] a);
      logic irq_e, xf_e;
      irq_e = !(a == `HBW_TF_STATCMD || a == `HBW_TF_SECNUM);
      xf_e = !(a == `HBW_TF_DATA || a == `HBW_TF_CYLLO);
      return {6'h00, xf_e, irq_e};
   endfunction

   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic fail();
      err_total++;
      test_done();
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      r_wr <= 1'b1;
      r_addr <= a;
      r_wdata <= d;
      @(posedge clk);
      r_wr <= 1'b0;
      #1;
   endtask

   task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      r_rd <= 1'b1;
      r_addr <= a;
      @(posedge clk);
      r_rd <= 1'b0;
      #1;
      d = r_rdata;
   endtask

   // ==================================================================
   // One permitted host access, serviced by the processor side
   task automatic host_xfer(input logic wr, input logic [2:0] a,
         input int slow);
      logic [7:0] hd, pd, rv;
      logic [31:0] t;
      int n;
      t = xs();
      hd = t[7:0];
      pd = t[15:8];
      hbw_host_model_i.start(wr, a, hd);
      n = 0;
      while (wait_n !== 1'b0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n >= 20) fail();
      reg_wr(`HBW_REG_CTRL, 8'h00);
      chk({7'h00, wait_n}, 8'h00);
      reg_wr(`HBW_REG_CTRL, 8'h01);
      rv = 8'h00;
      n = 0;
      while (rv[0] !== 1'b1 && n < 60) begin
         reg_rd(`HBW_REG_ACCESS, rv);
         n++;
      end
      chk(rv, {3'h0, wr, a, 1'b1});
      chk({6'h00, xfer, irq}, exp_req(a));
      chk({6'h00, oe, wait_n}, {6'h00, !wr, 1'b0});
      if (wr) begin
         reg_rd(`HBW_REG_LATCH, rv);
         chk(rv, hd);
      end else begin
         reg_wr(`HBW_REG_LATCH, pd);
         chk(hdo, pd);
      end
      chk({7'h00, wait_n}, 8'h01);
      hbw_host_model_i.finish(slow, ok);
      if (!ok) fail();
      chk({7'h00, oe}, 8'h00);
      n = 0;
      while (pulse_n !== 1'b1 && n < 80) begin
         @(posedge clk);
         n++;
      end
      #1;
      chk(pl_last[7:0], PULSE_LEN);
      // Let the access snapshot tick past this access before the next poll
      repeat (64) @(posedge clk);
   endtask

   // ==================================================================
   // Main sequence
   initial begin
      nrst = 1'b0;
      mclr_n = 1'b1;
      r_addr = 3'h0;
      r_wdata = 8'h00;
      r_wr = 1'b0;
      r_rd = 1'b0;
      seed = 32'h00012DAF;
      err_total = 0;
      n_checks = 0;
      pl_cnt = 0;
      pl_last = 0;
      hold_seen = 1'b0;
      addrs = '{3'h5, 3'h1, `HBW_TF_DATA, `HBW_TF_CYLLO, `HBW_TF_SECNUM,
         `HBW_TF_STATCMD};
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({wait_n, oe, irq, xfer, intr, pulse_n, 2'b00}, 8'hA4);
      reg_wr(3'h6, 8'hFF);
      reg_rd(3'h6, v);
      chk(v, 8'h00);
      reg_rd(`HBW_REG_CTRL, v);
      chk(v, `HBW_CTRL_RST);
      reg_rd(`HBW_REG_IMASK, v);
      chk(v, `HBW_MASK_RST);
      // Busy simulation: permit granted only after select fell
      reg_wr(`HBW_REG_LATCH, 8'h5A);
      hbw_host_model_i.start(1'b0, `HBW_TF_STATCMD, 8'h00);
      repeat (4) @(posedge clk);
      reg_wr(`HBW_REG_CTRL, 8'h01);
      chk({oe, hdo[6:0]}, 8'hDA);
      hbw_host_model_i.finish(10, ok);
      chk({6'h00, hold_seen, irq}, 8'h01);
      reg_rd(`HBW_REG_ISTAT, v);
      chk(v, 8'h00);
      // Request set and clear per byte, over every task-file class
      for (int i = 0; i < 6; i++) begin
         reg_wr(`HBW_REG_EVENT, 8'h03);
         reg_rd(`HBW_REG_EVENT, v);
         chk(v, 8'h03);
         r = xs();
         host_xfer(r[0], addrs[i], i * 3);
      end
      // Sticky status, mask and write-one-to-clear
      chk({7'h00, intr}, 8'h00);
      reg_rd(`HBW_REG_ISTAT, v);
      chk(v, 8'h03);
      reg_wr(`HBW_REG_IMASK, 8'h01);
      chk({7'h00, intr}, 8'h01);
      reg_wr(`HBW_REG_ISTAT, 8'h01);
      chk({7'h00, intr}, 8'h00);
      reg_wr(`HBW_REG_IMASK, 8'h02);
      chk({7'h00, intr}, 8'h01);
      reg_wr(`HBW_REG_ISTAT, 8'h02);
      chk({7'h00, intr}, 8'h00);
      // Master clear sets the interrupt and drops the request
      @(posedge clk);
      mclr_n <= 1'b0;
      repeat (3) @(posedge clk);
      mclr_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk({6'h00, xfer, irq}, 8'h01);
      test_done();
   end
endmodule
